// >>> common/tap_consts.svh
// Register offsets, field positions, reset values and timing counts of the tap timing block.
`ifndef TAP_CONSTS_SVH
`define TAP_CONSTS_SVH

`define IDX_THRESH_X 10'h023
`define IDX_THRESH_Y 10'h024
`define IDX_THRESH_Z 10'h025
`define IDX_DUR_LIMIT 10'h026
`define IDX_LATENCY 10'h027
`define IDX_CONTROL 10'h040
`define IDX_STATUS 10'h041

`define RST_THRESH 8'h00
`define RST_DUR_LIMIT 8'h00
`define RST_LATENCY 8'h00
`define RST_CONTROL 8'h00

`define THRESH_MSB 7
`define CTRL_RATE_LSB 0
`define CTRL_MODE_LSB 3
`define CTRL_LPF_BIT 5
`define CTRL_HYBRID_BIT 6

`define CLK_PERIOD_NS 50
`define BASE_STEP_NS 625000
`define BASE_STEP_CYCLES (`BASE_STEP_NS / `CLK_PERIOD_NS)

`define CAP_NORMAL_LPF_ON 13'h0020
`define CAP_HIRES_LPF_ON 13'h0004
`define CAP_NORMAL_LPF_OFF 13'h0008

`endif

// >>> common/tap_pkg.sv
// Types shared by the tap timing block.
package tap_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_LOW_NOISE = 2'h1,
        MODE_HIRES = 2'h2,
        MODE_LOW_POWER = 2'h3
    } power_mode_t;

    typedef struct packed {
        logic hybrid;
        logic lowpass_filter_on;
        power_mode_t mode;
        logic [2:0] output_sample_rate;
    } tap_ctrl_t;

    typedef struct packed {
        logic signed [13:0] x;
        logic signed [13:0] y;
        logic signed [13:0] z;
    } accel_sample_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_PULSE = 4'b0010,
        ST_HOLD = 4'b0100,
        ST_LAT = 4'b1000
    } tap_state_t;
endpackage

// >>> design/step_tick_gen.sv
// Divides the base step enable into one tick per programmed number of base steps.
`timescale 1ns/100ps
module step_tick_gen (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Control.
    input wire logic run,
    input wire logic base_tick,
    input wire logic [12:0] units,
    // Step enable.
    output logic tick_r
);
    logic [12:0] cnt_r;

    // Restarting while idle counts the first step from zero, but the free-running base tick can make it up to one base step short.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 13'h0000;
            tick_r <= 1'b0;
        end else if (!run) begin
            cnt_r <= 13'h0000;
            tick_r <= 1'b0;
        end else if (base_tick) begin
            if (cnt_r + 13'h0001 >= units) begin
                cnt_r <= 13'h0000;
                tick_r <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 13'h0001;
                tick_r <= 1'b0;
            end
        end else begin
            tick_r <= 1'b0;
        end
    end
endmodule

// >>> design/tap_timing.sv
// Tap threshold and timing block: per-axis thresholds, pulse time limit and latency, APB registers.
`timescale 1ns/100ps
`include "tap_consts.svh"
module tap_timing #(
    parameter int BASE_CYCLES = `BASE_STEP_CYCLES
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Acceleration samples at the selected range.
    input wire logic sample_valid,
    input wire tap_pkg::accel_sample_t sample,
    input wire logic [1:0] accel_range_select,
    // Detection events.
    output logic pulse_start,
    output logic pulse_end,
    output logic latency_expired,
    output logic [2:0] pulse_axis
);
    import tap_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Functions.

    // Rescales a 14-bit sample of 2g, 4g or 8g range to an 8g magnitude of 7 bits.
    function automatic logic [6:0] mag_8g(input logic signed [13:0] v, input logic [1:0] rng);
        logic signed [13:0] s;
        logic [13:0] a;
        s = (rng == 2'h2) ? (v >>> 6) : (rng == 2'h1) ? (v >>> 7) : (v >>> 8);
        a = s[13] ? 14'(-s) : 14'(s);
        mag_8g = (a > 14'h007F) ? 7'h7F : a[6:0];
    endfunction

    // Time limit step in units of 0.625 ms; latency doubles it.
    function automatic logic [12:0] step_units(input tap_ctrl_t c, input logic latency);
        logic [3:0] sh;
        logic [12:0] u;
        unique case (c.output_sample_rate)
            3'h0: sh = 4'h0;
            3'h1: sh = 4'h1;
            3'h2: sh = 4'h2;
            3'h3: sh = 4'h3;
            3'h4: sh = 4'h4;
            3'h5: sh = 4'h6;
            3'h6: sh = 4'h7;
            default: sh = 4'h9;
        endcase
        u = 13'h0002 << sh;
        if (c.lowpass_filter_on) begin
            if (c.mode == MODE_NORMAL && u > `CAP_NORMAL_LPF_ON) u = `CAP_NORMAL_LPF_ON;
            if (c.mode == MODE_HIRES && u > `CAP_HIRES_LPF_ON) u = `CAP_HIRES_LPF_ON;
        end else begin
            unique case (c.mode)
                MODE_LOW_POWER: u = u >> 1;
                MODE_HIRES: u = 13'h0001;
                default: u = (u > 13'h0004) ? (u >> 2) : 13'h0001;
            endcase
            if (c.mode == MODE_NORMAL && u > `CAP_NORMAL_LPF_OFF) u = `CAP_NORMAL_LPF_OFF;
        end
        if (latency) u = u << 1;
        if (c.hybrid) u = u << 1;
        step_units = u;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [6:0] thresh_x_r, thresh_y_r, thresh_z_r;
    logic [7:0] dur_limit_r, latency_r;
    tap_ctrl_t ctrl_r;
    tap_state_t st_r;
    logic [7:0] tl_cnt_r, lat_cnt_r;
    logic [9:0] idx;
    logic wr_en, rd_setup, mapped;
    logic [7:0] rd_val;

    assign idx = paddr[11:2];
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_setup = psel && !penable;

    always_comb begin
        mapped = 1'b1;
        rd_val = 8'h00;
        unique case (idx)
            `IDX_THRESH_X: rd_val = {1'b0, thresh_x_r};
            `IDX_THRESH_Y: rd_val = {1'b0, thresh_y_r};
            `IDX_THRESH_Z: rd_val = {1'b0, thresh_z_r};
            `IDX_DUR_LIMIT: rd_val = dur_limit_r;
            `IDX_LATENCY: rd_val = latency_r;
            `IDX_CONTROL: rd_val = {1'b0, ctrl_r};
            `IDX_STATUS: rd_val = {1'b0, pulse_axis, st_r};
            default: mapped = 1'b0;
        endcase
        if (paddr[1:0] != 2'h0) mapped = 1'b0;
    end

    // Answer one cycle after setup, so every access has exactly one access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= rd_setup;
            pslverr <= rd_setup && !mapped;
            prdata <= (rd_setup && !pwrite && mapped) ? {24'h000000, rd_val} : 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thresh_x_r <= 7'(`RST_THRESH);
            thresh_y_r <= 7'(`RST_THRESH);
            thresh_z_r <= 7'(`RST_THRESH);
            dur_limit_r <= `RST_DUR_LIMIT;
            latency_r <= `RST_LATENCY;
            ctrl_r <= tap_ctrl_t'(7'(`RST_CONTROL));
        end else if (wr_en && paddr[1:0] == 2'h0) begin
            unique case (idx)
                `IDX_THRESH_X: thresh_x_r <= pwdata[6:0];
                `IDX_THRESH_Y: thresh_y_r <= pwdata[6:0];
                `IDX_THRESH_Z: thresh_z_r <= pwdata[6:0];
                `IDX_DUR_LIMIT: dur_limit_r <= pwdata[7:0];
                `IDX_LATENCY: latency_r <= pwdata[7:0];
                `IDX_CONTROL: ctrl_r <= tap_ctrl_t'(pwdata[6:0]);
                default: ;
            endcase
        end
    end

    a_thresh_top_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && !pslverr && $past(idx) == `IDX_THRESH_X) |-> prdata[`THRESH_MSB] == 1'b0)
        else $error("threshold top bit not zero");

    ////////////////////////////////////////////////////////////////////////////
    // Timing base.

    logic [13:0] base_cnt_r;
    logic base_tick_r;
    logic tl_tick, lat_tick;
    logic [12:0] tl_units, lat_units;

    assign tl_units = step_units(ctrl_r, 1'b0);
    assign lat_units = step_units(ctrl_r, 1'b1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_cnt_r <= 14'h0000;
            base_tick_r <= 1'b0;
        end else if (base_cnt_r >= 14'(BASE_CYCLES - 1)) begin
            base_cnt_r <= 14'h0000;
            base_tick_r <= 1'b1;
        end else begin
            base_cnt_r <= base_cnt_r + 14'h0001;
            base_tick_r <= 1'b0;
        end
    end

    step_tick_gen u_tl_tick (
        .pclk(pclk),
        .presetn(presetn),
        .run(st_r == ST_PULSE),
        .base_tick(base_tick_r),
        .units(tl_units),
        .tick_r(tl_tick)
    );

    step_tick_gen u_lat_tick (
        .pclk(pclk),
        .presetn(presetn),
        .run(st_r == ST_LAT),
        .base_tick(base_tick_r),
        .units(lat_units),
        .tick_r(lat_tick)
    );

    a_step_lpf_on: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r.lowpass_filter_on && !ctrl_r.hybrid && ctrl_r.output_sample_rate == 3'h0) |-> tl_units == 13'h0002)
        else $error("limit step at 800 Hz with filter on is not 1.25 ms");
    a_step_hires_off: assert property (@(posedge pclk) disable iff (!presetn)
        (!ctrl_r.lowpass_filter_on && !ctrl_r.hybrid && ctrl_r.mode == MODE_HIRES) |-> tl_units == 13'h0001)
        else $error("high resolution limit step with filter off is not 0.625 ms");
    a_lat_double: assert property (@(posedge pclk) disable iff (!presetn)
        lat_units == (tl_units << 1))
        else $error("latency step is not twice the limit step");
    a_hybrid_double: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r.hybrid && $stable(ctrl_r.output_sample_rate) && $stable(ctrl_r.mode)
         && $stable(ctrl_r.lowpass_filter_on) && !$past(ctrl_r.hybrid)) |-> tl_units == ($past(tl_units) << 1))
        else $error("hybrid operation did not double the step");

    ////////////////////////////////////////////////////////////////////////////
    // Detection sequence.

    logic [2:0] over;
    logic any_over;

    // Each axis is compared only against its own threshold, in the fixed 8g scale.
    assign over[0] = mag_8g(sample.x, accel_range_select) > thresh_x_r;
    assign over[1] = mag_8g(sample.y, accel_range_select) > thresh_y_r;
    assign over[2] = mag_8g(sample.z, accel_range_select) > thresh_z_r;
    assign any_over = sample_valid && (over != 3'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_IDLE;
            pulse_start <= 1'b0;
            pulse_end <= 1'b0;
            latency_expired <= 1'b0;
            pulse_axis <= 3'h0;
        end else begin
            pulse_start <= 1'b0;
            pulse_end <= 1'b0;
            latency_expired <= 1'b0;
            unique case (st_r)
                ST_IDLE: begin
                    if (any_over) begin
                        st_r <= ST_PULSE;
                        pulse_start <= 1'b1;
                        pulse_axis <= over;
                    end
                end
                ST_PULSE: begin
                    if (tl_cnt_r >= dur_limit_r) begin
                        st_r <= ST_HOLD;
                    end else if (sample_valid && !any_over) begin
                        st_r <= ST_LAT;
                        pulse_end <= 1'b1;
                    end
                end
                ST_HOLD: begin
                    // A pulse that overran must settle before a new one may start.
                    if (sample_valid && !any_over) st_r <= ST_IDLE;
                end
                ST_LAT: begin
                    if (lat_cnt_r >= latency_r) begin
                        st_r <= ST_IDLE;
                        latency_expired <= 1'b1;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // Counts are raw steps compared directly with the register values.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tl_cnt_r <= 8'h00;
        end else if (st_r != ST_PULSE) begin
            tl_cnt_r <= 8'h00;
        end else if (tl_tick && tl_cnt_r != 8'hFF) begin
            tl_cnt_r <= tl_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_cnt_r <= 8'h00;
        end else if (st_r != ST_LAT) begin
            lat_cnt_r <= 8'h00;
        end else if (lat_tick && lat_cnt_r != 8'hFF) begin
            lat_cnt_r <= lat_cnt_r + 8'h01;
        end
    end

    a_start_cause: assert property (@(posedge pclk) disable iff (!presetn)
        pulse_start |-> $past(st_r) == ST_IDLE && $past(any_over) && pulse_axis == $past(over))
        else $error("pulse start without a threshold crossing");
    a_range_fixed: assert property (@(posedge pclk) disable iff (!presetn)
        (accel_range_select == 2'h2 && !sample.x[13] && sample.x[12:6] > thresh_x_r) |-> over[0])
        else $error("8g rescaling of the sample is wrong");
    a_limit_abort: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == ST_PULSE && tl_cnt_r >= dur_limit_r) |=> st_r == ST_HOLD && !pulse_end)
        else $error("pulse not aborted at time limit");
    a_end_in_time: assert property (@(posedge pclk) disable iff (!presetn)
        pulse_end |-> $past(tl_cnt_r) < $past(dur_limit_r) && st_r == ST_LAT)
        else $error("pulse end accepted after time limit");
    a_lat_ignore: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == ST_LAT) |=> !pulse_start)
        else $error("pulse start during latency");
    a_lat_expiry: assert property (@(posedge pclk) disable iff (!presetn)
        latency_expired |-> $past(lat_cnt_r) >= $past(latency_r) && $past(st_r) == ST_LAT && st_r == ST_IDLE)
        else $error("latency expired early");
    a_count_on_tick: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == ST_PULSE && $past(st_r) == ST_PULSE && tl_cnt_r != $past(tl_cnt_r)) |-> $past(tl_tick))
        else $error("limit counter advanced without a step tick");
endmodule

// >>> verification/testbench.sv
// Self-checking testbench of the tap threshold and timing block.
`timescale 1ns/100ps
`include "tap_consts.svh"
module testbench;
    import tap_pkg::*;
    // A short base step keeps the slowest rates within a sensible run length.
    localparam int BASE = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_valid, err;
    logic pulse_start, pulse_end, latency_expired;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, d;
    logic [1:0] accel_range_select;
    logic [2:0] pulse_axis, ax;
    accel_sample_t sample;
    tap_ctrl_t ctrl;
    int failures, checks_done, n, t0, u, g, r, lat, th[3], vi[3], zero[3];
    logic [9:0] regs[5];

    tap_timing #(.BASE_CYCLES(BASE)) tap_timing_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_valid(sample_valid), .sample(sample), .accel_range_select(accel_range_select),
        .pulse_start(pulse_start), .pulse_end(pulse_end), .latency_expired(latency_expired),
        .pulse_axis(pulse_axis)
    );

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Latency step in base units; the limit step is half of it.
    function automatic int units(int rate, int mode, bit lpf, bit hyb);
        int s[8];
        int v;
        s = '{0, 1, 2, 3, 4, 6, 7, 9};
        v = 2 << s[rate];
        if (lpf) begin
            if (mode == 0 && v > 32) v = 32;
            if (mode == 2 && v > 4) v = 4;
        end else if (mode == 3) begin
            v = v / 2;
        end else if (mode == 2) begin
            v = 1;
        end else begin
            v = (v / 4 < 1) ? 1 : v / 4;
            if (mode == 0 && v > 8) v = 8;
        end
        return hyb ? 4 * v : 2 * v;
    endfunction

    function automatic logic pick(int sel);
        return (sel == 0) ? pulse_start : (sel == 1) ? pulse_end : latency_expired;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [1:0] lo, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, lo};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            chk(32'(pready), 32'h1);
            close_out;
        end
    endtask

    task automatic setup(input int rate, input int mode, input bit lpf, input bit hyb, input int lim, input int lt);
        ctrl.output_sample_rate = 3'(rate);
        ctrl.mode = power_mode_t'(mode);
        ctrl.lowpass_filter_on = lpf;
        ctrl.hybrid = hyb;
        apb(1'b1, `IDX_CONTROL, 2'b00, {25'h0, ctrl});
        apb(1'b1, `IDX_DUR_LIMIT, 2'b00, 32'(lim));
        apb(1'b1, `IDX_LATENCY, 2'b00, 32'(lt));
    endtask

    // Values are in 8g steps and are widened to the chosen range before driving.
    task automatic send(input int v[3], input int rg);
        int sh;
        sh = 8 - rg;
        @(posedge pclk);
        sample.x <= 14'(v[0] <<< sh);
        sample.y <= 14'(v[1] <<< sh);
        sample.z <= 14'(v[2] <<< sh);
        accel_range_select <= 2'(rg);
        sample_valid <= 1'b1;
        @(posedge pclk);
        sample_valid <= 1'b0;
        #1;
    endtask

    task automatic wait_for(input int sel, input int limv, input bit must, output int cnt);
        logic s;
        cnt = 0;
        s = pick(sel);
        while (s !== 1'b1 && cnt < limv) begin
            @(posedge pclk);
            #1;
            cnt++;
            s = pick(sel);
        end
        if (must && s !== 1'b1) begin
            chk(32'(s), 32'h1);
            close_out;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, sample_valid, presetn} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        sample = '0;
        accel_range_select = 2'h2;
        failures = 0;
        checks_done = 0;
        zero = '{0, 0, 0};
        regs = '{`IDX_THRESH_X, `IDX_THRESH_Y, `IDX_THRESH_Z, `IDX_DUR_LIMIT, `IDX_LATENCY};
        void'($urandom(32'h726E18AF));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, `IDX_THRESH_X, 2'b01, 32'hFF);
        chk(32'(err), 32'h1);
        apb(1'b0, 10'h3FF, 2'b00, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
        foreach (regs[i]) begin
            apb(1'b0, regs[i], 2'b00, 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, `IDX_STATUS, 2'b00, 32'h0);
        chk(rd, 32'h1);
        $display("test reset values done");
        foreach (regs[i]) begin
            d = $urandom;
            apb(1'b1, regs[i], 2'b00, d);
            apb(1'b0, regs[i], 2'b00, 32'h0);
            chk(rd, d & ((i < 3) ? 32'h7F : 32'hFF));
        end
        $display("test register access done");
        setup(0, 2, 1'b1, 1'b0, 255, 0);
        foreach (th[a]) begin
            th[a] = 10 + $urandom % 30;
            apb(1'b1, regs[a], 2'b00, 32'(th[a]) | 32'h80);
        end
        repeat (12) begin
            r = $urandom % 3;
            foreach (vi[a]) begin
                g = $urandom % (32 << r);
                vi[a] = $urandom % 2 ? -g : g;
                ax[a] = g > th[a];
            end
            send(vi, r);
            chk(32'(pulse_start), 32'(ax != 0));
            if (ax != 0) begin
                chk(32'(pulse_axis), 32'(ax));
                send(zero, r);
                wait_for(1, 20, 1'b1, n);
                wait_for(2, 20, 1'b1, n);
            end
        end
        $display("test axis thresholds done");
        // A 16-cycle pulse against a 3-step limit: inside it with the filter on, past it with it off.
        for (int lpf = 1; lpf >= 0; lpf--) begin
            setup(0, 2, lpf != 0, 1'b0, 3, 0);
            send('{127, 0, 0}, 2);
            repeat (14) @(posedge pclk);
            send(zero, 2);
            wait_for(1, 4, 1'b0, n);
            chk(32'(n < 4), 32'(lpf));
            if (lpf != 0) wait_for(2, 20, 1'b1, n);
            apb(1'b0, `IDX_STATUS, 2'b00, 32'h0);
            chk(rd & 32'hF, 32'h1);
        end
        $display("test time limit done");
        for (int rate = 0; rate < 8; rate++) begin
            lat = rate < 3 ? 1 + $urandom % 3 : 1;
            d[0] = 1'($urandom);
            d[1] = rate < 5 ? 1'($urandom) : 1'b0;
            u = lat * BASE * units(rate, rate % 4, d[0], d[1]);
            setup(rate, rate % 4, d[0], d[1], 255, lat);
            send('{0, 0, 127}, 2);
            send(zero, 2);
            wait_for(1, 4, 1'b1, n);
            t0 = $time;
            send('{0, 127, 0}, 2);
            chk(32'(pulse_start), 32'h0);
            chk(32'(pulse_axis), 32'h4);
            wait_for(2, u + 20, 1'b1, n);
            n = ($time - t0) / 50;
            chk(32'(n >= u - BASE - 1 && n <= u + 2), 32'h1);
        end
        $display("test latency steps done");
        close_out;
    end
endmodule
